// File: logic/sld_pkg.sv
package sld_pkg;
  localparam int          SLD_DATA_BITS  = 35;
  localparam int          SLD_FRAME_CLKS = 36;
  localparam int          SLD_SEG_CNT    = 23;
  localparam int          SLD_CNT_W      = 6;
  // Maximum serial clock, in kHz
  localparam int          SLD_SCLK_MAX_KHZ = 500;
  localparam int          SLD_SYS_KHZ    = 20000;
  // Source divider: half period in system cycles, rounded up to keep <= max
  localparam int          SLD_HALF_CYC   =
    (SLD_SYS_KHZ + 2 * SLD_SCLK_MAX_KHZ - 1) / (2 * SLD_SCLK_MAX_KHZ);
  localparam int          SLD_DIV_W      = 8;
  // Data bit number (1-based, after start bit) feeding each segment 1..23
  localparam logic [5:0]  SLD_MAP [SLD_SEG_CNT] = '{
    6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
    6'h0c, 6'h0d, 6'h0e, 6'h0f,
    6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19,
    6'h1b,
    6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22};
  typedef enum logic [1:0] {SLD_IDLE, SLD_LOW, SLD_HIGH} sld_src_st_t;
endpackage

// File: logic/sld_link_if.sv
`timescale 1ns/1ps
interface sld_link_if;
  logic sclk;
  logic sdata;
  modport src (output sclk, output sdata);
  modport drv (input sclk, input sdata);
endinterface

// File: logic/sld_source.sv
`timescale 1ns/1ps
// Serial data source: sends start bit then 35 data bits, 36 clocks
module sld_source
  import sld_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_b_i,
  // User side
  input  wire logic                         send_i,
  input  wire logic [SLD_DATA_BITS-1:0]     data_i,
  output logic                              busy_o,
  // Link
  sld_link_if.src                           link
);
  import sld_pkg::*;

  sld_src_st_t              st_q, st_d;
  logic [SLD_DIV_W-1:0]     div_q, div_d;
  logic [SLD_CNT_W-1:0]     cnt_q, cnt_d;
  logic [SLD_FRAME_CLKS-1:0] sh_q, sh_d;
  logic                     sclk_q, sclk_d;
  logic                     sd_q, sd_d;

  localparam logic [SLD_DIV_W-1:0] HALF_M1 = SLD_DIV_W'(SLD_HALF_CYC - 1);
  localparam logic [SLD_CNT_W-1:0] LAST    = SLD_CNT_W'(SLD_FRAME_CLKS - 1);

  always_comb begin
    st_d   = st_q;
    div_d  = div_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    sclk_d = sclk_q;
    sd_d   = sd_q;
    case (st_q)
      SLD_IDLE: begin
        sclk_d = 1'b0;
        if (send_i) begin
          // Start bit first, then data bit 1 (data_i[0]) onward
          sh_d  = {data_i, 1'b1};
          sd_d  = 1'b1;
          cnt_d = '0;
          div_d = '0;
          st_d  = SLD_LOW;
        end
      end
      SLD_LOW: begin
        // Data changes only while clock is low
        if (div_q == HALF_M1) begin
          div_d  = '0;
          sclk_d = 1'b1;
          st_d   = SLD_HIGH;
        end else begin
          div_d = div_q + 1'b1;
        end
      end
      SLD_HIGH: begin
        if (div_q == HALF_M1) begin
          div_d  = '0;
          sclk_d = 1'b0;
          // Always a full 36 clocks per frame
          if (cnt_q == LAST) begin
            st_d = SLD_IDLE;
            sd_d = 1'b0;
          end else begin
            cnt_d = cnt_q + 1'b1;
            sh_d  = {1'b0, sh_q[SLD_FRAME_CLKS-1:1]};
            sd_d  = sh_q[1];
            st_d  = SLD_LOW;
          end
        end else begin
          div_d = div_q + 1'b1;
        end
      end
      default: st_d = SLD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q   <= SLD_IDLE;
      div_q  <= '0;
      cnt_q  <= '0;
      sh_q   <= '0;
      sclk_q <= 1'b0;
      sd_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      div_q  <= div_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      sclk_q <= sclk_d;
      sd_q   <= sd_d;
    end
  end

  // Only two link wires
  assign link.sclk  = sclk_q;
  assign link.sdata = sd_q;
  assign busy_o     = (st_q != SLD_IDLE);
endmodule

// File: logic/sld_driver.sv
`timescale 1ns/1ps
module sld_driver
  import sld_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Link
  sld_link_if.drv                       link,
  // Segment outputs, high = sink on
  output logic [SLD_SEG_CNT-1:0]        seg_on_o,
  output logic                          load_o
);
  import sld_pkg::*;

  logic                       ck_s1_q, ck_s2_q, ck_s3_q;
  logic                       dt_s1_q, dt_s2_q;
  logic [SLD_FRAME_CLKS-1:0]  sh_q, sh_d;
  logic [SLD_CNT_W-1:0]       cnt_q, cnt_d;
  logic                       clr_pend_q, clr_pend_d;
  logic [SLD_SEG_CNT-1:0]     seg_q, seg_d;
  logic                       load_q, load_d;
  logic                       rise, fall;

  localparam logic [SLD_CNT_W-1:0] LAST = SLD_CNT_W'(SLD_FRAME_CLKS - 1);

  // Link pins pass two flip-flops before use
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      dt_s1_q <= 1'b0;
      dt_s2_q <= 1'b0;
    end else begin
      ck_s1_q <= link.sclk;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      dt_s1_q <= link.sdata;
      dt_s2_q <= dt_s1_q;
    end
  end

  assign rise = ck_s2_q & ~ck_s3_q;
  assign fall = ~ck_s2_q & ck_s3_q;

  // Shift register holds start bit in [35], data bit n in [35-n]

  always_comb begin
    sh_d       = sh_q;
    cnt_d      = cnt_q;
    clr_pend_d = clr_pend_q;
    seg_d      = seg_q;
    load_d     = 1'b0;
    if (rise) begin
      // Bits taken on rising edge; state held between edges
      sh_d = {sh_q[SLD_FRAME_CLKS-2:0], dt_s2_q};
      // Frame begins when a start one is seen
      if (cnt_q != '0 || dt_s2_q) begin
        cnt_d = cnt_q + 1'b1;
      end
      if (cnt_q == LAST) begin
        // 36th clock high: load strobe
        load_d     = 1'b1;
        clr_pend_d = 1'b1;
        cnt_d      = '0;
        // Only mapped positions reach outputs
        for (int i = 0; i < SLD_SEG_CNT; i++) begin
          // Same value reloads unchanged, so output holds
          seg_d[i] = sh_d[SLD_DATA_BITS - int'(SLD_MAP[i])];
        end
      end
    end
    if (fall && clr_pend_q) begin
      // 36th clock low: clear shifter nothing pending in first
      // stage since the next start is sampled only at the next rise
      sh_d       = '0;
      clr_pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    // Power-on reset clears shifter and latches
    if (!rst_b_i) begin
      sh_q       <= '0;
      cnt_q      <= '0;
      clr_pend_q <= 1'b0;
      seg_q      <= '0;
      load_q     <= 1'b0;
    end else begin
      sh_q       <= sh_d;
      cnt_q      <= cnt_d;
      clr_pend_q <= clr_pend_d;
      seg_q      <= seg_d;
      load_q     <= load_d;
    end
  end

  assign seg_on_o = seg_q;
  assign load_o   = load_q;
endmodule

// File: tb/sld_link_asserts.sv
`timescale 1ns/1ps
module sld_link_asserts
  import sld_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  input wire logic                   sclk,
  input wire logic                   sdata,
  input wire logic                   busy_o,
  input wire logic                   load_o,
  input wire logic [SLD_SEG_CNT-1:0] seg_on_o
);
  logic [5:0] rise_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Link clock rises since the last load
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise_q <= 6'h00;
    end else begin
      rise_q <= load_o ? 6'h00 : rise_q + 6'($rose(sclk));
    end
  end
  a_seg_hold_stable: assert property (!load_o |-> $stable(seg_on_o))
    else $error("segments changed without a load");
  a_load_one_cycle: assert property (load_o |=> !load_o)
    else $error("load lasted more than one cycle");
  a_sclk_high_min: assert property ($rose(sclk) |-> sclk[*8])
    else $error("link clock high phase too short");
  a_data_stable_high: assert property (sclk |-> $stable(sdata))
    else $error("data moved while link clock high");
  a_start_bit_one: assert property ($rose(busy_o) |-> sdata && !sclk)
    else $error("frame did not open with a one");
  a_load_count: assert property (load_o |-> rise_q == 6'h24)
    else $error("load not after the last clock of a frame");
  a_frame_clks: assert property ($rose(sclk) |-> rise_q < 6'h24)
    else $error("frame ran past its last clock");
  a_reset_clear: assert property ($rose(rst_b_i) |-> seg_on_o == '0)
    else $error("segments not cleared by reset");
endmodule

// File: tb/test_serial_led_segment_latch_driver.sv
`timescale 1ns/1ps
module test_serial_led_segment_latch_driver;
  import sld_pkg::*;
  logic                     clk_i;
  logic                     rst_b_i;
  logic                     send_i;
  logic [SLD_DATA_BITS-1:0] data_i;
  logic                     busy_o;
  logic                     load_o;
  logic [SLD_SEG_CNT-1:0]   seg_on_o;
  int                       errors;
  int                       samples_checked;
  int                       seed;
  int                       i;
  sld_link_if u_sld_link_if ();
  sld_source u_sld_source (.clk_i(clk_i), .rst_b_i(rst_b_i), .send_i(send_i),
    .data_i(data_i), .busy_o(busy_o), .link(u_sld_link_if));
  sld_driver u_sld_driver (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .link(u_sld_link_if), .seg_on_o(seg_on_o), .load_o(load_o));
  sld_link_asserts u_sld_link_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sclk(u_sld_link_if.sclk), .sdata(u_sld_link_if.sdata),
    .busy_o(busy_o), .load_o(load_o), .seg_on_o(seg_on_o));
  // Segment pattern expected from one frame's data bits
  function automatic logic [SLD_SEG_CNT-1:0] seg_of(
    logic [SLD_DATA_BITS-1:0] d);
    return {d[33:29], d[26], d[24:19], d[14:11], d[7:1]};
  endfunction
  task automatic complete_run();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(logic [SLD_SEG_CNT-1:0] got,
                       logic [SLD_SEG_CNT-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One whole frame; checks the segments in the load cycle
  task automatic send(logic [SLD_DATA_BITS-1:0] d);
    int  n;
    bit  seen;
    n = 0;
    seen = 0;
    send_i = 1'b1;
    data_i = d;
    while (!(seen && busy_o === 1'b0)) begin
      @(posedge clk_i);
      #1;
      n++;
      if (busy_o === 1'b1) send_i = 1'b0;
      if (load_o === 1'b1) begin
        seen = 1;
        check(seg_on_o, seg_of(d));
      end
      if (n > 3000) begin
        errors++;
        complete_run();
      end
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    rst_b_i = 1'b0;
    send_i = 1'b0;
    data_i = '0;
    seed = 32'h3a0b;
    repeat (4) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    check(seg_on_o, '0);
    send({SLD_DATA_BITS{1'b1}});
    send({SLD_DATA_BITS{1'b1}});
    send('0);
    for (i = 0; i < SLD_DATA_BITS; i++) begin
      send(35'h1 << i);
    end
    repeat (8) send(35'({$random(seed), $random(seed)}));
    // Reset in mid-frame, then resume
    send_i = 1'b1;
    repeat (300) @(posedge clk_i);
    #1 rst_b_i = 1'b0;
    send_i = 1'b0;
    #1 check(seg_on_o, '0);
    @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    send(35'h2aaaaaaaa);
    complete_run();
  end
endmodule
